// [verilog/dlc_pkg.sv]
package dlc_pkg;

	// ==========================================================
	// register map, byte addresses on the apb bus
	// ==========================================================
	localparam logic [11:0] DLC_OFF_CTRL   = 12'h000;  // channel_control
	localparam logic [11:0] DLC_OFF_STATUS = 12'h004;  // channel_status
	localparam logic [11:0] DLC_OFF_COUNT  = 12'h008;  // byte_count_remaining

	// ==========================================================
	// channel_control field positions
	// ==========================================================
	localparam int DLC_SECOND_LSB = 0;   // second_link_target, 2 bits
	localparam int DLC_FIRST_LSB  = 2;   // first_link_target, 2 bits
	localparam int DLC_COND_LSB   = 4;   // link_condition_select, 2 bits
	localparam int DLC_RSVD_BIT   = 6;   // always reads zero
	localparam int DLC_AUTODIS_BIT = 7;  // auto-disable request enable
	localparam int DLC_CIRC_LSB   = 8;   // circular buffer size code, 4 bits
	localparam int DLC_CS_BIT     = 16;  // cycle-steal select
	localparam int DLC_ERQ_BIT    = 17;  // periph_request_enable
	localparam int DLC_START_BIT  = 18;  // software start, self clearing

	// channel_status field positions
	localparam int DLC_CE_BIT     = 0;   // configuration error
	localparam int DLC_DONE_BIT   = 1;   // byte count exhausted

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [31:0] DLC_CTRL_RST  = 32'h0000_0000;
	localparam logic [23:0] DLC_COUNT_RST = 24'h00_0000;

	// ==========================================================
	// encodings
	// ==========================================================
	typedef enum logic [1:0] {
		DLC_LINK_NONE       = 2'h0,  // no linking
		DLC_LINK_EACH_SPLIT = 2'h1,  // first each steal, second at end
		DLC_LINK_EACH       = 2'h2,  // first after each steal
		DLC_LINK_AT_END     = 2'h3   // first when count hits zero
	} dlc_link_e;

	localparam logic [3:0] DLC_CIRC_OFF  = 4'h0;  // no wrapping
	localparam logic [3:0] DLC_CIRC_128K = 4'hE;  // 128 KB modulo
	localparam logic [3:0] DLC_CIRC_256K = 4'hF;  // 256 KB modulo
	localparam int         DLC_CIRC_BASE = 3;     // code 1 means 2**(1+3) bytes

endpackage : dlc_pkg

// [verilog/dlc_link_ctrl.sv]
// ==========================================================
// small shift fifo: head entry and its valid are flip-flops
// ==========================================================
module dlc_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 4
) (
	input  wire logic             i_core_clk,  // core clock
	input  wire logic             i_rst_b,     // async reset, low
	input  wire logic             i_in_valid,  // push request
	output logic                  o_in_ready,  // room for one word
	input  wire logic [WIDTH-1:0] i_in_data,   // pushed word
	output logic                  o_out_valid, // head holds a word
	input  wire logic             i_out_ready, // consumer takes head
	output logic [WIDTH-1:0]      o_out_data,  // head word
	output logic [$clog2(DEPTH+1)-1:0] o_level // words held
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [DEPTH-1:0] vld_q;
	logic [DEPTH-1:0] vld_d;
	logic             push;
	logic             pop;

	assign o_in_ready  = !vld_q[DEPTH-1];
	assign o_out_valid = vld_q[0];
	assign o_out_data  = mem_q[0];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = i_out_ready && vld_q[0];

	// level is a popcount, entries are always packed at the bottom
	always_comb begin
		o_level = '0;
		for (int i = 0; i < DEPTH; i++) begin
			o_level = o_level + {{($clog2(DEPTH+1)-1){1'b0}}, vld_q[i]};
		end
	end

	// shift down on pop, then place a push in the first free slot
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
			vld_d[i] = vld_q[i];
		end
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_d[i] = mem_q[i+1];
				vld_d[i] = vld_q[i+1];
			end
			vld_d[DEPTH-1] = 1'b0;
		end
		// slot 0 is handled apart so no select ever reaches index -1
		if (push) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				if (!vld_d[i] && vld_d[i-1]) begin
					mem_d[i] = i_in_data;
					vld_d[i] = 1'b1;
				end
			end
			if (!vld_d[0]) begin
				mem_d[0] = i_in_data;
				vld_d[0] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			vld_q <= '0;
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
		end else begin
			vld_q <= vld_d;
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= mem_d[i];
		end
	end
endmodule : dlc_fifo

// Operation
// - size code 1110 wraps at 128 KB
// - size code 1111 wraps at 256 KB
// - auto-disable set: count zero clears request enable
// - auto-disable clear: request enable stays unchanged
// - control bit 6 always reads zero
// - link condition 00: no linking at all
// - 01: first each steal, second at end
// - 10: first after every completed steal
// - 11: first only when count reaches zero
// - continuous mode: 01 and 10 skip first
// - link means a request into target channel
// - first target bits 3-2 name channels 0-3
// - second target bits 1-0 name channels 0-3
// - self-link sets configuration error, no link
// - cycle-steal one transfer per request, else run
// - request enable gates peripheral request recognition
// - size code 0000 means no wrapping
module dlc_link_ctrl
	import dlc_pkg::*;
#(
	parameter logic [1:0] CH_ID   = 2'h0,  // this channel's number
	parameter int         COUNT_W = 24,    // byte count width
	parameter int         FIFO_D  = 4      // link request fifo depth
) (
	input  wire logic               i_core_clk,     // 20 MHz core clock
	input  wire logic               i_rst_b,        // async reset, low
	input  wire logic               i_psel,         // apb select
	input  wire logic               i_penable,      // apb access phase
	input  wire logic               i_pwrite,       // apb direction
	input  wire logic [11:0]        i_paddr,        // apb byte address
	input  wire logic [31:0]        i_pwdata,       // apb write data
	output logic [31:0]             o_prdata,       // apb read data
	output logic                    o_pready,       // apb ready
	output logic                    o_pslverr,      // unmapped address
	input  wire logic               i_periph_req,   // peripheral pin, async
	input  wire logic               i_link_in,      // link request from a peer
	input  wire logic               i_xfer_done,    // one transfer finished
	input  wire logic [2:0]         i_xfer_bytes,   // bytes moved: 1, 2 or 4
	output logic                    o_xfer_ready,   // engine may finish a transfer
	output logic                    o_chan_req,     // request to arbitration
	output logic                    o_cycle_steal,  // one transfer per request
	output logic [17:0]             o_wrap_mask,    // address modulo mask
	output logic                    o_link_valid,   // link request pending
	output logic [1:0]              o_link_chan,    // channel to be requested
	input  wire logic               i_link_ready,   // arbiter took link request
	output logic                    o_config_err    // configuration error flag
);

	// ==========================================================
	// helpers
	// ==========================================================
	// code n>0 selects a 2**(n+3) byte buffer; the mask is size-1
	function automatic logic [17:0] wrap_mask(input logic [3:0] code);
		logic [18:0] size;
		size = 19'h0_0001 << (5'(code) + 5'(DLC_CIRC_BASE));  // five bits: E, F must not wrap
		if (code == DLC_CIRC_OFF) return 18'h0_0000;
		return 18'(size - 19'h0_0001);
	endfunction : wrap_mask

	// ==========================================================
	// registers
	// ==========================================================
	logic [31:0]        ctrl_q;
	logic [31:0]        ctrl_d;
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] count_d;
	logic               ce_q;
	logic               done_q;
	logic               sync1_q;
	logic               sync2_q;
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;
	logic               chan_req_q;
	logic               xfer_ready_q;
	logic [17:0]        wrap_q;

	// ==========================================================
	// apb decode
	// ==========================================================
	wire setup_ph  = i_psel && !i_penable;
	wire wr_acc    = i_psel && i_penable && i_pwrite && pready_q;
	wire hit_ctrl  = (i_paddr == DLC_OFF_CTRL);
	wire hit_stat  = (i_paddr == DLC_OFF_STATUS);
	wire hit_count = (i_paddr == DLC_OFF_COUNT);
	wire hit_any   = hit_ctrl || hit_stat || hit_count;
	wire wr_ctrl   = wr_acc && hit_ctrl;
	wire wr_stat   = wr_acc && hit_stat;
	wire wr_count  = wr_acc && hit_count;

	// ==========================================================
	// control fields
	// ==========================================================
	wire [1:0] second_link_target    = ctrl_q[DLC_SECOND_LSB +: 2];
	wire [1:0] first_link_target     = ctrl_q[DLC_FIRST_LSB +: 2];
	wire [1:0] link_condition_select = ctrl_q[DLC_COND_LSB +: 2];
	wire       auto_disable          = ctrl_q[DLC_AUTODIS_BIT];
	wire [3:0] circ_code             = ctrl_q[DLC_CIRC_LSB +: 4];
	wire       cycle_steal           = ctrl_q[DLC_CS_BIT];
	wire       periph_request_enable = ctrl_q[DLC_ERQ_BIT];
	wire       start_bit             = ctrl_q[DLC_START_BIT];

	// ==========================================================
	// byte count and exhaustion
	// ==========================================================
	// a short last transfer saturates at zero rather than wrapping
	wire [COUNT_W-1:0] bytes_w = COUNT_W'(i_xfer_bytes);
	wire [COUNT_W-1:0] count_after = (count_q > bytes_w) ?
		(count_q - bytes_w) : '0;
	wire final_xfer = i_xfer_done && (count_after == '0);

	// ==========================================================
	// link decision
	// ==========================================================
	wire cond_none  = (link_condition_select == DLC_LINK_NONE);
	wire cond_split = (link_condition_select == DLC_LINK_EACH_SPLIT);
	wire cond_each  = (link_condition_select == DLC_LINK_EACH);
	wire cond_end   = (link_condition_select == DLC_LINK_AT_END);
	// per-steal links need cycle-steal mode, end links do not
	wire want_first = i_xfer_done && (
		(cycle_steal && cond_split && !final_xfer) ||
		(cycle_steal && cond_each) ||
		(cond_end && final_xfer));
	wire want_second = cond_split && final_xfer;
	wire self_named  = (first_link_target == CH_ID) ||
		(second_link_target == CH_ID);
	wire self_err    = i_xfer_done && !cond_none && self_named;
	wire link_push   = (want_first || want_second) && !self_err;
	wire [1:0] link_target = want_second ? second_link_target :
		first_link_target;

	// ==========================================================
	// link request fifo
	// ==========================================================
	logic       fifo_in_ready;
	logic [2:0] fifo_level;
	dlc_fifo #(
		.WIDTH (2),
		.DEPTH (FIFO_D)
	) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (link_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (link_target),
		.o_out_valid (o_link_valid),
		.i_out_ready (i_link_ready),
		.o_out_data  (o_link_chan),
		.o_level     (fifo_level)
	);

	// engine is held off while one more push could overflow the fifo
	wire fifo_pop   = o_link_valid && i_link_ready;
	wire [2:0] level_next = fifo_level + {2'b00, link_push && fifo_in_ready}
		- {2'b00, fifo_pop};
	wire xfer_ready_d = (level_next < 3'(FIFO_D));

	// ==========================================================
	// control register next value
	// ==========================================================
	// software write wins over the hardware clears in the same cycle
	wire erq_clear   = final_xfer && auto_disable;
	wire start_clear = start_bit;  // start lives one cycle, then fires
	always_comb begin
		ctrl_d = ctrl_q;
		if (erq_clear) ctrl_d[DLC_ERQ_BIT] = 1'b0;
		if (start_clear) ctrl_d[DLC_START_BIT] = 1'b0;
		if (wr_ctrl) ctrl_d = i_pwdata;
		ctrl_d[DLC_RSVD_BIT] = 1'b0;
		ctrl_d[31:19] = '0;
		ctrl_d[15:12] = '0;
	end

	// count: software load, else decrement per finished transfer
	assign count_d = wr_count ? i_pwdata[COUNT_W-1:0] :
		(i_xfer_done ? count_after : count_q);

	// ==========================================================
	// read mux
	// ==========================================================
	wire [31:0] status_word = {30'h0, done_q, ce_q};
	wire [31:0] rd_word = hit_ctrl  ? ctrl_q :
		hit_stat  ? status_word :
		hit_count ? {{(32-COUNT_W){1'b0}}, count_q} : 32'h0000_0000;

	// ==========================================================
	// channel request to arbitration
	// ==========================================================
	// peripheral request counts only while its enable is set; a peer's
	// link counts like any other request, priority is the arbiter's
	wire chan_req_d = start_bit ||
		(periph_request_enable && sync2_q) ||
		i_link_in;

	// ==========================================================
	// processes
	// ==========================================================
	// peripheral pin synchroniser
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= i_periph_req;
			sync2_q <= sync1_q;
		end
	end

	// programming model
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q  <= DLC_CTRL_RST;
			count_q <= COUNT_W'(DLC_COUNT_RST);
		end else begin
			ctrl_q  <= ctrl_d;
			count_q <= count_d;
		end
	end

	// status flags: a hardware set beats a write-one clear
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ce_q   <= 1'b0;
			done_q <= 1'b0;
		end else begin
			ce_q   <= self_err ||
				(ce_q && !(wr_stat && i_pwdata[DLC_CE_BIT]));
			done_q <= final_xfer ||
				(done_q && !(wr_stat && i_pwdata[DLC_DONE_BIT]));
		end
	end

	// apb answer: data latched in setup, ready in the access cycle
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= (setup_ph && !i_pwrite) ? rd_word : 32'h0000_0000;
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph && !hit_any;
		end
	end

	// outputs toward the transfer engine and arbiter
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			chan_req_q   <= 1'b0;
			xfer_ready_q <= 1'b0;
			wrap_q       <= 18'h0_0000;
		end else begin
			chan_req_q   <= chan_req_d;
			xfer_ready_q <= xfer_ready_d;
			wrap_q       <= wrap_mask(circ_code);
		end
	end

	// the engine reads this to do one transfer per request or run on
	assign o_cycle_steal = ctrl_q[DLC_CS_BIT];
	assign o_chan_req    = chan_req_q;
	assign o_xfer_ready  = xfer_ready_q;
	assign o_wrap_mask   = wrap_q;
	assign o_config_err  = ce_q;
	assign o_prdata      = prdata_q;
	assign o_pready      = pready_q;
	assign o_pslverr     = pslverr_q;

endmodule : dlc_link_ctrl

// [tb/dlc_link_ctrl_asserts.sv]
module dlc_link_ctrl_asserts #(
	parameter logic [1:0] CH_ID = 2'h0  // channel number watched
) (
	input wire logic        i_core_clk,   // core clock
	input wire logic        i_rst_b,      // async reset, low
	input wire logic        i_psel,       // apb select
	input wire logic        i_penable,    // apb access phase
	input wire logic        i_pwrite,     // apb direction
	input wire logic        o_pready,     // apb ready
	input wire logic        o_pslverr,    // apb error
	input wire logic [31:0] o_prdata,     // apb read data
	input wire logic        i_xfer_done,  // transfer finished
	input wire logic        i_link_ready, // arbiter pop
	input wire logic        o_link_valid, // link head valid
	input wire logic [1:0]  o_link_chan,  // link head channel
	input wire logic [17:0] o_wrap_mask,  // modulo mask
	input wire logic        o_config_err  // configuration error
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// ==========================================================
	// bus side
	// ==========================================================
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_answer;
		o_pready ##1 !o_pready;
	endsequence
	chk_apb_answer: assert property (s_setup |=> s_answer)
		else $error("ready not a single pulse after setup");
	chk_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	chk_rd_quiet: assert property (!(i_psel && i_penable && !i_pwrite) |-> o_prdata == 32'h0)
		else $error("read data outside a read access");
	// ==========================================================
	// link side
	// ==========================================================
	chk_link_holds: assert property (
		o_link_valid && !i_link_ready |=> o_link_valid && $stable(o_link_chan))
		else $error("link request dropped or changed");
	chk_link_cause: assert property ($rose(o_link_valid) |-> $past(i_xfer_done))
		else $error("link request without a transfer");
	chk_no_self: assert property (o_link_valid |-> o_link_chan != CH_ID)
		else $error("link to own channel");
	chk_err_cause: assert property ($rose(o_config_err) |-> $past(i_xfer_done))
		else $error("error flag without a transfer");
	// mask is all ones from bit 0, at least 16 bytes, or zero
	chk_wrap_form: assert property (o_wrap_mask != 18'h0 |->
		o_wrap_mask[3:0] == 4'hF && (o_wrap_mask & (o_wrap_mask + 18'h1)) == 18'h0)
		else $error("wrap mask malformed");
endmodule : dlc_link_ctrl_asserts

bind dlc_link_ctrl dlc_link_ctrl_asserts #(.CH_ID(CH_ID)) dlc_link_ctrl_asserts_inst (
	.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
	.i_xfer_done(i_xfer_done), .i_link_ready(i_link_ready), .o_link_valid(o_link_valid),
	.o_link_chan(o_link_chan), .o_wrap_mask(o_wrap_mask), .o_config_err(o_config_err));

// [tb/dlc_partner.sv]
module dlc_partner (
	input  wire logic  i_core_clk,   // core clock
	input  wire logic  i_xfer_ready, // channel can take a transfer end
	input  wire logic  i_link_valid, // link request pending
	input  wire logic  i_stall,      // arbiter busy elsewhere
	output logic       o_xfer_done,  // transfer finished pulse
	output logic [2:0] o_xfer_bytes, // size of that transfer
	output logic       o_link_ready, // arbiter takes the link
	output logic       o_peer_link   // a peer channel's link into us
);
	timeunit 1ns;
	timeprecision 1ns;
	// arbiter grants at once unless held off by the bench
	assign o_link_ready = i_link_valid && !i_stall;
	initial begin
		o_xfer_done = 1'b0;
		o_xfer_bytes = 3'h0;
		o_peer_link = 1'b0;
	end
	// engine: one transfer per call, only while the channel is ready
	task automatic xfer(input logic [2:0] b);
		do
			@(negedge i_core_clk);
		while (i_xfer_ready !== 1'b1);
		@(posedge i_core_clk);
		o_xfer_done  <= 1'b1;
		o_xfer_bytes <= b;
		@(posedge i_core_clk);
		o_xfer_done  <= 1'b0;
		o_xfer_bytes <= ~b; // stale size must not look valid
	endtask : xfer
	// peer channel: holds its link request at the level asked for
	task automatic peer_link(input logic lvl);
		o_peer_link <= lvl;
	endtask : peer_link
endmodule : dlc_partner

// [tb/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dlc_pkg::*;
	logic        i_core_clk, i_rst_b, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        i_periph_req, i_link_in, i_xfer_done, o_xfer_ready, o_chan_req, err;
	logic        o_cycle_steal, o_link_valid, i_link_ready, o_config_err, stall;
	logic [2:0]  i_xfer_bytes;
	logic [17:0] o_wrap_mask;
	logic [1:0]  o_link_chan;
	logic [1:0]  popped[$];
	int          error_cnt = 0;
	int          n_compared = 0;

	dlc_link_ctrl dlc_link_ctrl_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_periph_req(i_periph_req), .i_link_in(i_link_in), .i_xfer_done(i_xfer_done),
		.i_xfer_bytes(i_xfer_bytes), .o_xfer_ready(o_xfer_ready), .o_chan_req(o_chan_req),
		.o_cycle_steal(o_cycle_steal), .o_wrap_mask(o_wrap_mask), .o_link_valid(o_link_valid),
		.o_link_chan(o_link_chan), .i_link_ready(i_link_ready), .o_config_err(o_config_err));
	dlc_partner dlc_partner_inst (.i_core_clk(i_core_clk), .i_xfer_ready(o_xfer_ready),
		.i_link_valid(o_link_valid), .i_stall(stall), .o_xfer_done(i_xfer_done),
		.o_xfer_bytes(i_xfer_bytes), .o_link_ready(i_link_ready), .o_peer_link(i_link_in));

	// ==========================================================
	// clock, pop monitor, shared tasks
	// ==========================================================
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		if (o_link_valid && i_link_ready)
			popped.push_back(o_link_chan);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one full transfer, then an idle cycle so strobes never collide
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		i_psel   <= 1'b1;
		i_pwrite <= wr;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_core_clk);
		while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask : apb
	task automatic results();
		$display("compared %0d, wrong %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_regs();
		apb(1'b0, DLC_OFF_CTRL, 32'h0);
		check(rd, DLC_CTRL_RST);
		apb(1'b1, DLC_OFF_CTRL, 32'hFFFB_FFFF); // start left out
		apb(1'b0, DLC_OFF_CTRL, 32'h0);
		check(rd, 32'h0003_0FBF);
		check({14'h0, o_wrap_mask}, 32'h0003_FFFF);
		check({31'h0, o_cycle_steal}, 32'h1);
		apb(1'b1, DLC_OFF_CTRL, 32'h0000_0E00);
		@(negedge i_core_clk); // mask register lags the control write by one edge
		check({14'h0, o_wrap_mask}, 32'h0001_FFFF);
		@(posedge i_core_clk);
		apb(1'b1, DLC_OFF_CTRL, 32'h0);
		@(negedge i_core_clk);
		check({14'h0, o_wrap_mask}, 32'h0);
		check({31'h0, o_cycle_steal}, 32'h0);
		@(posedge i_core_clk);
		apb(1'b0, 12'h00C, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test regs done");
	endtask : t_regs
	// rows: condition, cycle steal, pops expected, popped channels
	task automatic t_link();
		logic [15:0] tbl[7] = '{16'h0100, 16'h112B, 16'h212A, 16'h3118, 16'h101C,
			16'h2000, 16'h3018};
		foreach (tbl[i]) begin
			popped.delete();
			apb(1'b1, DLC_OFF_CTRL, {15'h0, tbl[i][8], 10'h0, tbl[i][13:12], 4'hB});
			apb(1'b1, DLC_OFF_COUNT, 32'h2);
			dlc_partner_inst.xfer(3'h1);
			dlc_partner_inst.xfer(3'h1);
			repeat (4) @(posedge i_core_clk);
			check(popped.size(), tbl[i][5:4]);
			for (int k = 0; k < popped.size(); k++)
				check(popped[k], tbl[i][3-2*k -: 2]);
		end
		$display("test link done");
	endtask : t_link
	// own channel named first, then second
	task automatic t_self();
		logic [31:0] cfg[2] = '{32'h0001_0023, 32'h0001_0018};
		foreach (cfg[i]) begin
			popped.delete();
			apb(1'b1, DLC_OFF_CTRL, cfg[i]);
			apb(1'b1, DLC_OFF_COUNT, 32'h1);
			dlc_partner_inst.xfer(3'h1);
			repeat (4) @(posedge i_core_clk);
			check(popped.size(), 32'h0);
			apb(1'b0, DLC_OFF_STATUS, 32'h0);
			check(rd, 32'h3);
			check(o_config_err, 32'h1);
			apb(1'b1, DLC_OFF_STATUS, 32'h3);
		end
		$display("test self done");
	endtask : t_self
	task automatic t_erq();
		i_periph_req <= 1'b1;
		apb(1'b1, DLC_OFF_CTRL, 32'h0);
		repeat (6) @(posedge i_core_clk);
		check(o_chan_req, 32'h0);
		apb(1'b1, DLC_OFF_CTRL, 32'h0002_0080);
		repeat (4) @(posedge i_core_clk);
		check(o_chan_req, 32'h1);
		apb(1'b1, DLC_OFF_COUNT, 32'h4);
		dlc_partner_inst.xfer(3'h4);
		apb(1'b0, DLC_OFF_CTRL, 32'h0);
		check(rd, 32'h0000_0080);
		repeat (4) @(posedge i_core_clk);
		check(o_chan_req, 32'h0);
		apb(1'b1, DLC_OFF_CTRL, 32'h0002_0000);
		apb(1'b1, DLC_OFF_COUNT, 32'h2);
		dlc_partner_inst.xfer(3'h2);
		apb(1'b0, DLC_OFF_CTRL, 32'h0);
		check(rd, 32'h0002_0000);
		i_periph_req <= 1'b0;
		apb(1'b1, DLC_OFF_CTRL, 32'h0);
		// software start: one request cycle, then the bit clears itself
		apb(1'b1, DLC_OFF_CTRL, 32'h0004_0000);
		@(negedge i_core_clk);
		check(o_chan_req, 32'h1);
		@(negedge i_core_clk);
		check(o_chan_req, 32'h0);
		@(posedge i_core_clk);
		dlc_partner_inst.peer_link(1'b1);
		repeat (3) @(posedge i_core_clk);
		check(o_chan_req, 32'h1);
		dlc_partner_inst.peer_link(1'b0);
		repeat (3) @(posedge i_core_clk);
		check(o_chan_req, 32'h0);
		$display("test request enable done");
	endtask : t_erq
	// arbiter stalls until the four-deep queue refuses, then drains
	task automatic t_fifo();
		popped.delete();
		stall <= 1'b1;
		apb(1'b1, DLC_OFF_CTRL, 32'h0001_002B);
		apb(1'b1, DLC_OFF_COUNT, 32'h10);
		repeat (4) dlc_partner_inst.xfer(3'h1);
		@(negedge i_core_clk);
		check(o_xfer_ready, 32'h0);
		@(posedge i_core_clk);
		stall <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		check(popped.size(), 32'h4);
		check(o_link_valid, 32'h0);
		$display("test queue done");
	endtask : t_fifo

	// ==========================================================
	// main sequence and watchdog
	// ==========================================================
	initial begin
		i_rst_b = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		i_periph_req = 1'b0;
		stall = 1'b0;
		repeat (12) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		@(posedge i_core_clk);
		t_regs();
		t_link();
		t_self();
		t_erq();
		t_fifo();
		results();
	end
	// a few hundred cycles expected; ten thousand means a hang
	initial begin
		#500000;
		error_cnt++;
		results();
	end
endmodule : testbench
